// >>> dv/serial_peer.sv
// serial line partner: the modem side that sends frames into the receiver
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input wire logic CORE_CLK,
    input wire logic SAMPLE_TICK,
    output var logic RX_PIN
);
    // an idle line rests at mark, so nothing is read as a start bit between frames
    initial RX_PIN = 1'b1;

    // wait for n sample ticks, then step just past the edge before driving
    task automatic ticks(input int n);
        repeat (n) @(posedge CORE_CLK iff SAMPLE_TICK);
        #1;
    endtask : ticks

    // one bit lasts 16 sample ticks; data leaves LSB first, eight data bits
    task automatic send(input logic [7:0] d, input logic par_on, input logic p,
                        input logic stp);
        logic [10:0] f;
        int n;
        f = {stp, p, d, 1'b0};
        n = par_on ? 11 : 10;
        if (!par_on) begin
            f[9] = stp;
        end
        ticks(1);
        for (int i = 0; i < n; i++) begin
            RX_PIN = f[i];
            ticks(16);
        end
        RX_PIN = 1'b1;
    endtask : send
endmodule : serial_peer
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the receive status, compare and echo channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic core_clk, reset_n, tick, rx_line, tx_serial, tx_under, echo_en;
    logic data_rd, cmp_wr, tx_pin, tx_flag;
    logic [7:0] cmp_data, rx_data;
    rx_echo_pkg::rx_cfg_t cfg;
    rx_echo_pkg::rx_status_t st;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    rx_status_echo dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .SAMPLE_TICK(tick),
        .RX_PIN(rx_line), .TX_SERIAL(tx_serial), .TX_UNDERRUN(tx_under),
        .ECHO_EN(echo_en), .CFG(cfg), .DATA_RD(data_rd), .CMP_WR(cmp_wr),
        .CMP_DATA(cmp_data), .TX_PIN(tx_pin), .RX_DATA(rx_data), .STATUS(st),
        .TX_UNDERRUN_FLAG(tx_flag));
    serial_peer peer (.CORE_CLK(core_clk), .SAMPLE_TICK(tick), .RX_PIN(rx_line));

    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // sample tick every second cycle keeps a frame short (32 cycles a bit)
    always @(posedge core_clk) #1 tick = ~tick;
    // hang guard: the whole run needs well under 15000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // host read of the holding word, one-cycle strobe; done before the next stop bit
    task automatic rd();
        data_rd = 1'b1;
        step(1);
        data_rd = 1'b0;
        step(1);
        `CHK(st.word_ready, 1'h0)
    endtask : rd

    function automatic logic good_par(input logic [1:0] m, input logic [7:0] d);
        case (m)
            2'h0: return ~^d;
            2'h1: return ^d;
            2'h2: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : good_par

    task automatic t_normal_overrun();
        peer.send(8'hA5, 1'b0, 1'b0, 1'b1);
        `CHK(st.word_ready, 1'h1)
        `CHK(rx_data, 8'hA5)
        rd();
        peer.send(8'h11, 1'b0, 1'b0, 1'b1);
        peer.send(8'h22, 1'b0, 1'b0, 1'b1);
        `CHK(st.overrun, 1'h1)
        `CHK(rx_data, 8'h11)
        rd();
        `CHK(st.overrun, 1'h0)
        peer.send(8'h33, 1'b0, 1'b0, 1'b1);
        `CHK(rx_data, 8'h33)
        rd();
        // five-bit words land in the low bits, upper bits read zero
        cfg.len_sel = 2'h0;
        peer.send(8'hF5, 1'b0, 1'b0, 1'b1);
        `CHK(rx_data, 8'h15)
        rd();
        cfg.len_sel = rx_echo_pkg::RESET_LEN_SEL;
    endtask : t_normal_overrun

    task automatic t_framing_break();
        peer.send(8'h5A, 1'b0, 1'b0, 1'b0);
        `CHK(st.framing_err, 1'h1)
        `CHK(st.word_ready, 1'h1)
        rd();
        peer.send(8'hC3, 1'b0, 1'b0, 1'b1);
        `CHK(st.framing_err, 1'h0)
        rd();
        peer.send(8'h00, 1'b0, 1'b0, 1'b0);
        `CHK(st.break_seen, 1'h1)
        `CHK(st.word_ready, 1'h0)
        peer.send(8'h81, 1'b0, 1'b0, 1'b1);
        `CHK(rx_data, 8'h81)
        rd();
    endtask : t_framing_break

    // format changes only between frames, never while a word is arriving
    task automatic t_parity();
        cfg.parity_en = 1'b1;
        for (int m = 0; m < 4; m++) begin
            cfg.parity_mode = m[1:0];
            peer.send(8'h07, 1'b1, ~good_par(m[1:0], 8'h07), 1'b1);
            `CHK(st.parity_status, 1'h1)
            rd();
        end
        peer.send(8'h07, 1'b1, good_par(2'h3, 8'h07), 1'b1);
        `CHK(st.parity_status, 1'h0)
        rd();
        cfg.par_shows_bit = 1'b1;
        peer.send(8'hF0, 1'b1, 1'b1, 1'b1);
        `CHK(st.parity_status, 1'h1)
        rd();
        peer.send(8'hF1, 1'b1, 1'b0, 1'b1);
        `CHK(st.parity_status, 1'h0)
        rd();
        cfg.parity_en = 1'b0;
        cfg.par_shows_bit = 1'b0;
    endtask : t_parity

    // compare register reached directly; the select bit is taken as cleared
    task automatic t_compare();
        peer.send(8'h55, 1'b0, 1'b0, 1'b1);
        cmp_data = 8'h3C;
        cmp_wr = 1'b1;
        step(1);
        cmp_wr = 1'b0;
        step(1);
        `CHK(st.sleeping, 1'h1)
        `CHK(st.word_ready, 1'h0)
        peer.send(8'h11, 1'b0, 1'b0, 1'b1);
        `CHK(st.word_ready, 1'h0)
        peer.send(8'h3C, 1'b0, 1'b0, 1'b1);
        `CHK(st.word_ready, 1'h0)
        `CHK(st.sleeping, 1'h0)
        peer.send(8'h77, 1'b0, 1'b0, 1'b1);
        `CHK(st.word_ready, 1'h1)
        `CHK(rx_data, 8'h77)
        rd();
    endtask : t_compare

    task automatic t_echo();
        logic [9:0] f;
        f = {1'b1, 8'h4B, 1'b0};
        tx_serial = 1'b0;
        echo_en = 1'b1;
        step(8);
        `CHK(tx_pin, 1'h0)
        tx_under = 1'b1;
        step(40);
        `CHK(tx_flag, 1'h0)
        `CHK(tx_pin, 1'h1)
        fork
            peer.send(8'h4B, 1'b0, 1'b0, 1'b1);
        join_none
        @(negedge rx_line);
        #1;
        // sample late in each echoed bit, where an undelayed copy shows the next bit
        peer.ticks(4);
        for (int k = 0; k < 10; k++) begin
            peer.ticks(16);
            `CHK(tx_pin, f[k])
        end
        wait fork;
        echo_en = 1'b0;
        rd();
        step(8);
        `CHK(tx_pin, 1'h1)
        `CHK(tx_flag, 1'h1)
        tx_under = 1'b0;
        step(8);
        `CHK(tx_flag, 1'h0)
        `CHK(tx_pin, 1'h0)
    endtask : t_echo

    // main sequence: reset for 12 cycles, then one scenario after another
    initial begin
        reset_n = 1'b0;
        tick = 1'b0;
        tx_serial = 1'b1; // an idle transmitter rests at mark
        tx_under = 1'b0;
        echo_en = 1'b0;
        data_rd = 1'b0;
        cmp_wr = 1'b0;
        cmp_data = 8'h00;
        cfg = '0;
        cfg.len_sel = rx_echo_pkg::RESET_LEN_SEL;
        step(12);
        reset_n = 1'b1;
        step(1);
        `CHK(tx_pin, 1'h1)
        `CHK(st, 6'h00)
        `CHK(rx_data, rx_echo_pkg::RESET_BYTE)
        t_normal_overrun();
        t_framing_break();
        t_parity();
        t_compare();
        t_echo();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire

// >>> pkg/rx_echo_pkg.sv
// shared constants and carrier types for the receive/echo channel
package rx_echo_pkg;
    // oversampling: one bit time is this many sample ticks
    localparam int unsigned OVERSAMPLE = 16;
    localparam logic [3:0] MID_SAMPLE = 4'h7;     // bit centre
    localparam logic [3:0] STOP_FLAG_POINT = 4'h8; // ninth sample of the stop bit
    localparam logic [3:0] HALF_BIT = 4'h8;       // echo delay in ticks
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_LEN_SEL = 2'h3;  // 8 data bits
    localparam logic [1:0] PAR_NONE = 2'h0;

    // format control: word length 5..8 (code 0..3), parity check mode
    typedef struct packed {
        logic [1:0] len_sel;     // 0:5 bits .. 3:8 bits
        logic parity_en;         // a parity position follows the data
        logic [1:0] parity_mode; // 0 odd, 1 even, 2 mark, 3 space
        logic par_shows_bit;     // aux bit 0: report received parity bit
    } rx_cfg_t;

    // status seen by the host
    typedef struct packed {
        logic word_ready;
        logic overrun;
        logic parity_status;
        logic framing_err;
        logic break_seen;
        logic sleeping;
    } rx_status_t;

    // one finished frame from the receive engine
    typedef struct packed {
        logic [7:0] data;
        logic par_bit;
        logic par_bad;
        logic stop_bad;
        logic is_break;
    } rx_frame_t;
endpackage : rx_echo_pkg

// >>> rtl/echo_delay.sv
// half-bit delay line used to retransmit received bits in echo mode
`timescale 1ns/1ps
`default_nettype none
module echo_delay (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic tick,
    input wire logic din,
    output logic dout
);
    logic [7:0] line_r;

    // eight sample ticks of history equal half a bit time
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            line_r <= 8'hFF;
        end else if (tick) begin
            line_r <= {line_r[6:0], din};
        end
    end

    assign dout = line_r[7];
endmodule : echo_delay
`default_nettype wire

// >>> rtl/rx_status_echo.sv
// receive status, compare/sleep and echo logic of one serial channel
// Notes on behaviour
// - in echo mode transmit line repeats receive line half a bit later
// - echo begins only once the transmitter has reached underrun
// - echo suppresses the underrun flag and the forced mark level
// - normally, missing next word holds line at mark and flags underrun
// - word-ready flag rises near nine-sixteenths through the stop bit
// - overrun sets flag, keeps unread word, drops new and later words
// - reading the data register after overrun resumes normal reception
// - break sets break flag, no word-ready, waits for stop bit
// - missing stop bit sets framing error together with word-ready
// - framing error reflects only the most recent word
// - parity status shows error, or received parity bit when aux bit set
// - with parity checking, wrong parity sets status with word-ready
// - in multidrop, parity position one marks address, zero marks data
// - with aux bit set, status bit is one for address frames
// - writing the compare value puts the channel to sleep
// - matching character wakes channel and is not itself flagged
// - the character after the match sets word-ready
`timescale 1ns/1ps
`default_nettype none
module rx_status_echo (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic SAMPLE_TICK,
    input wire logic RX_PIN,
    input wire logic TX_SERIAL,
    input wire logic TX_UNDERRUN,
    input wire logic ECHO_EN,
    input wire rx_echo_pkg::rx_cfg_t CFG,
    input wire logic DATA_RD,
    input wire logic CMP_WR,
    input wire logic [7:0] CMP_DATA,
    output logic TX_PIN,
    output logic [7:0] RX_DATA,
    output rx_echo_pkg::rx_status_t STATUS,
    output logic TX_UNDERRUN_FLAG
);
    typedef enum logic [2:0] {IDLE, START, DATA, PARITY, TAIL, STOP, BREAK_WAIT} rx_state_t;

    logic rx_s;
    logic echo_bit;
    rx_state_t state_r;
    logic [3:0] tick_cnt_r;
    logic [2:0] bit_idx_r;
    logic [7:0] shift_r;
    logic par_bit_r;
    logic stop_bad;
    logic frame_done;
    logic echo_live_r;
    logic [7:0] rx_holding_reg;
    logic rx_word_ready_flag;
    logic overrun_r;
    logic parity_status_bit;
    logic framing_r;
    logic break_r;
    logic sleep_r;
    logic [7:0] cmp_r;
    logic [7:0] word;
    logic par_bad;
    logic take_word;
    logic mid;
    logic stop_point;

    // returns the number of data bits minus one for the chosen length
    function automatic logic [2:0] last_bit(input logic [1:0] sel);
        last_bit = 3'h4 + {1'b0, sel};
    endfunction : last_bit

    // expected parity for the check modes, over the bits actually received
    function automatic logic want_par(input logic [7:0] d, input logic [1:0] m);
        case (m)
            2'h0: want_par = ~(^d);
            2'h1: want_par = ^d;
            2'h2: want_par = 1'b1;
            default: want_par = 1'b0;
        endcase
    endfunction : want_par

    rx_sync2 u_rx_sync (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .d(RX_PIN),
        .q(rx_s)
    );

    echo_delay u_echo (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .tick(SAMPLE_TICK),
        .din(rx_s),
        .dout(echo_bit)
    );

    assign mid = SAMPLE_TICK && (tick_cnt_r == rx_echo_pkg::MID_SAMPLE);
    assign stop_point = SAMPLE_TICK && (tick_cnt_r == rx_echo_pkg::STOP_FLAG_POINT);
    assign stop_bad = ~rx_s;

    // receive engine: start detect, data, optional parity, stop sampling
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            state_r <= IDLE;
            tick_cnt_r <= 4'h0;
            bit_idx_r <= 3'h0;
            shift_r <= rx_echo_pkg::RESET_BYTE;
            par_bit_r <= 1'b0;
        end else if (SAMPLE_TICK) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
            case (state_r)
                IDLE: begin
                    tick_cnt_r <= 4'h0;
                    if (!rx_s) begin
                        state_r <= START;
                    end
                end
                START: begin
                    if (tick_cnt_r == rx_echo_pkg::MID_SAMPLE) begin
                        // a glitch shorter than half a bit is not a start
                        state_r <= rx_s ? IDLE : DATA;
                        tick_cnt_r <= rx_s ? 4'h0 : 4'h8;
                        bit_idx_r <= 3'h0;
                        shift_r <= rx_echo_pkg::RESET_BYTE;
                        par_bit_r <= 1'b0; // no stale parity bit in the break test
                    end
                end
                DATA: begin
                    if (tick_cnt_r == rx_echo_pkg::MID_SAMPLE) begin
                        shift_r[bit_idx_r] <= rx_s;
                        bit_idx_r <= bit_idx_r + 3'h1;
                        if (bit_idx_r == last_bit(CFG.len_sel)) begin
                            state_r <= CFG.parity_en ? PARITY : TAIL;
                        end
                    end
                end
                PARITY: begin
                    if (tick_cnt_r == rx_echo_pkg::MID_SAMPLE) begin
                        par_bit_r <= rx_s;
                        state_r <= TAIL;
                    end
                end
                TAIL: begin
                    // run out the last bit so the stop bit is judged in its own time
                    if (&tick_cnt_r) begin
                        state_r <= STOP;
                    end
                end
                STOP: begin
                    // the stop bit is judged at its ninth sample
                    if (tick_cnt_r == rx_echo_pkg::STOP_FLAG_POINT) begin
                        // any low stop waits for mark, so it is never taken as a start
                        state_r <= stop_bad ? BREAK_WAIT : IDLE;
                    end
                end
                BREAK_WAIT: begin
                    tick_cnt_r <= 4'h0;
                    if (rx_s) begin
                        state_r <= IDLE;
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    assign word = shift_r;
    assign par_bad = CFG.parity_en && (par_bit_r != want_par(word, CFG.parity_mode));
    assign frame_done = stop_point && (state_r == STOP);
    // a break is an all-space frame including the stop position
    assign take_word = frame_done && !(stop_bad && word == 8'h00 && !par_bit_r);

    // sleep mode: armed by a compare write, released by a matching word
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            sleep_r <= 1'b0;
            cmp_r <= rx_echo_pkg::RESET_BYTE;
        end else if (CMP_WR) begin
            sleep_r <= 1'b1;
            cmp_r <= CMP_DATA;
        end else if (take_word && sleep_r && word == cmp_r) begin
            sleep_r <= 1'b0;
        end
    end

    // holding register and ready/overrun; a new word beats a same-cycle read
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            rx_holding_reg <= rx_echo_pkg::RESET_BYTE;
            rx_word_ready_flag <= 1'b0;
            overrun_r <= 1'b0;
        end else if (take_word && !sleep_r) begin
            if (rx_word_ready_flag && !DATA_RD) begin
                overrun_r <= 1'b1;
            end else if (!overrun_r || DATA_RD) begin
                rx_holding_reg <= word;
                rx_word_ready_flag <= 1'b1;
                overrun_r <= 1'b0;
            end
        end else if (DATA_RD) begin
            rx_word_ready_flag <= 1'b0;
            overrun_r <= 1'b0;
        end
        // a compare write drops the flag so nothing stands ready while asleep
        if (RESET_N && CMP_WR) begin
            rx_word_ready_flag <= 1'b0;
        end
    end

    // per-word error status updated exactly when a word is flagged
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            framing_r <= 1'b0;
            parity_status_bit <= 1'b0;
        end else if (take_word && !sleep_r && !(rx_word_ready_flag && !DATA_RD) &&
                (!overrun_r || DATA_RD)) begin
            framing_r <= stop_bad;
            // aux bit selects error report or raw address/data marker
            parity_status_bit <= CFG.par_shows_bit ? (CFG.parity_en && par_bit_r) :
                par_bad;
        end
    end

    // break status stays until the host reads data
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            break_r <= 1'b0;
        end else if (frame_done && !take_word) begin
            break_r <= 1'b1;
        end else if (DATA_RD) begin
            break_r <= 1'b0;
        end
    end

    // echo goes live only after the transmitter has underrun
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            echo_live_r <= 1'b0;
        end else if (!ECHO_EN) begin
            echo_live_r <= 1'b0;
        end else if (TX_UNDERRUN) begin
            echo_live_r <= 1'b1;
        end
    end

    // transmit pin: echo, forced mark on normal underrun, else serialiser
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            TX_PIN <= 1'b1;
            TX_UNDERRUN_FLAG <= 1'b0;
        end else if (echo_live_r) begin
            TX_PIN <= echo_bit;
            TX_UNDERRUN_FLAG <= 1'b0;
        end else if (TX_UNDERRUN && !ECHO_EN) begin
            TX_PIN <= 1'b1;
            TX_UNDERRUN_FLAG <= 1'b1;
        end else begin
            TX_PIN <= TX_SERIAL;
            TX_UNDERRUN_FLAG <= 1'b0;
        end
    end

    assign RX_DATA = rx_holding_reg;
    assign STATUS = '{word_ready: rx_word_ready_flag, overrun: overrun_r,
                      parity_status: parity_status_bit, framing_err: framing_r,
                      break_seen: break_r, sleeping: sleep_r};

    a_sleep_no_ready: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        sleep_r && $past(sleep_r) && !$past(CMP_WR) |-> !$rose(rx_word_ready_flag))
        else $error("word flagged while asleep");
    a_sleep_ready_low: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        sleep_r |-> !rx_word_ready_flag)
        else $error("ready flag high while asleep");
    a_read_clears: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        DATA_RD && !take_word |=> !rx_word_ready_flag)
        else $error("read left ready set");
    a_overrun_keeps: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        overrun_r && !DATA_RD |=> $stable(rx_holding_reg))
        else $error("holding word changed in overrun");
    a_overrun_sets: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        take_word && !sleep_r && rx_word_ready_flag && !DATA_RD |=> overrun_r)
        else $error("overrun missed");
    a_overrun_clear: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        overrun_r && DATA_RD && !take_word |=> !overrun_r)
        else $error("overrun not cleared by read");
    a_ready_at_stop: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(rx_word_ready_flag) |-> $past(frame_done))
        else $error("ready outside stop point");
    a_frame_err: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(rx_word_ready_flag) |-> framing_r == $past(stop_bad))
        else $error("framing error not per word");
    a_break_noready: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        frame_done && !take_word |=> break_r && state_r == BREAK_WAIT)
        else $error("break handling wrong");
    a_cmp_sleeps: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CMP_WR |=> sleep_r)
        else $error("compare write did not sleep");
    a_echo_gate: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ECHO_EN && !echo_live_r && !TX_UNDERRUN |=> !echo_live_r)
        else $error("echo started before underrun");
    a_echo_noflag: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        echo_live_r |=> !TX_UNDERRUN_FLAG)
        else $error("underrun flagged during echo");

    c_word: cover property (@(posedge CORE_CLK) $rose(rx_word_ready_flag));
    c_overrun: cover property (@(posedge CORE_CLK) $rose(overrun_r));
    c_wake: cover property (@(posedge CORE_CLK) $fell(sleep_r));
    c_echo: cover property (@(posedge CORE_CLK) $rose(echo_live_r));
endmodule : rx_status_echo
`default_nettype wire

// >>> rtl/rx_sync2.sv
// two-stage synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
`default_nettype none
module rx_sync2 (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic d,
    output logic q
);
    logic meta_r;

    // first stage feeds only the second; idle line level is mark
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            meta_r <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : rx_sync2
`default_nettype wire
